// *** src/acm_pkg.sv ***
// Shared constants and carrier types for the AC RMS current meter
package acm_pkg;

  // ****************************************
  // Clock rates and enable dividers
  // ****************************************
  localparam int CLK_HZ = 20_000_000;
  localparam int XTAL_HZ = 24_000_000;
  localparam int AUX_HZ = 3_000_000;
  localparam int SUB_MAIN_HZ = 6_000_000;
  localparam int MAIN_HZ = 24_000_000;
  localparam int PH_W = 20;
  // Phase increments for fractional enable dividers, rate * 2^PH_W / CLK_HZ
  localparam logic [PH_W-1:0] AUX_INC = PH_W'((longint'(AUX_HZ) << PH_W) / CLK_HZ);
  localparam logic [PH_W-1:0] SUB_INC = PH_W'((longint'(SUB_MAIN_HZ) << PH_W) / CLK_HZ);

  // ****************************************
  // Sampling and calibration timing
  // ****************************************
  localparam int SAMPLE_HZ = 5940;
  localparam int SMP_DIV = SUB_MAIN_HZ / SAMPLE_HZ;
  localparam int SMP_W = 11;
  localparam int CAL_TIME_S = 2;
  localparam int CAL_SAMPLES = CAL_TIME_S * SAMPLE_HZ;
  localparam int CNT_W = 14;

  // ****************************************
  // Converter scaling and datapath widths
  // ****************************************
  localparam int ADC_W = 12;
  localparam int ADC_FULL = 4095;
  localparam int VREF_MV = 3300;
  localparam int XQ = 8;
  localparam int THR_MV = 15;
  localparam logic [19:0] THR_XQ = 20'(THR_MV << XQ);
  localparam int ACC_W = 40;
  localparam int FIFO_DEPTH = 8;
  localparam logic [ADC_W-1:0] MX_RST = 12'h000;
  localparam logic [ADC_W-1:0] MN_RST = 12'hFFF;

  // ****************************************
  // Gain correction and current polynomial
  // ****************************************
  localparam int GAIN_FRAC = 14;
  localparam logic [15:0] GAIN_ONE = 16'h4000;
  localparam int POLY_Q = 16;
  localparam real COEF_A = -0.0000554;
  localparam real COEF_B = 0.0583711;
  localparam real COEF_C = 0.0712513;
  // Coefficients scaled to milliamps and Q16, truncated toward zero
  localparam longint COEF_A_Q = $rtoi(COEF_A * 1000.0 * 65536.0);
  localparam longint COEF_B_Q = $rtoi(COEF_B * 1000.0 * 65536.0);
  localparam longint COEF_C_Q = $rtoi(COEF_C * 1000.0 * 65536.0);

  // ****************************************
  // Carriers
  // ****************************************
  typedef struct packed {
    logic [ADC_W-1:0] code;
  } acm_sample_s;

  typedef struct packed {
    logic [ADC_W-1:0] rms;
    logic [ADC_W-1:0] pp;
    logic [15:0] cur_ma;
  } acm_result_s;

endpackage

// *** src/acm_fifo.sv ***
// Small sample FIFO with valid/ready on both sides
`timescale 1ns/1ps
module acm_fifo #(
  parameter int WIDTH = 12,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input logic clk_sys,
  input logic arst_n,
  // Filling side
  input logic in_valid,
  input logic [WIDTH-1:0] in_data,
  output logic in_ready,
  // Draining side
  output logic out_valid,
  output logic [WIDTH-1:0] out_data,
  input logic out_ready
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = AW + 1;

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wp_q, wp_d, rp_q, rp_d;
  logic [CW-1:0] cnt_q, cnt_d;
  logic in_ready_q, in_ready_d, out_valid_q, out_valid_d;
  logic push, pop;

  assign push = in_valid & in_ready_q;
  assign pop = out_ready & out_valid_q;
  assign in_ready = in_ready_q;
  assign out_valid = out_valid_q;
  assign out_data = mem[rp_q];

  // Pointers wrap explicitly so any depth works
  always_comb begin
    wp_d = wp_q;
    rp_d = rp_q;
    cnt_d = cnt_q;
    if (push) begin
      wp_d = (wp_q == AW'(DEPTH - 1)) ? '0 : wp_q + 1'b1;
    end
    if (pop) begin
      rp_d = (rp_q == AW'(DEPTH - 1)) ? '0 : rp_q + 1'b1;
    end
    if (push && !pop) begin
      cnt_d = cnt_q + 1'b1;
    end else if (pop && !push) begin
      cnt_d = cnt_q - 1'b1;
    end
    in_ready_d = (cnt_d != CW'(DEPTH));
    out_valid_d = (cnt_d != '0);
  end

  // Flags are registered so both handshake outputs come from flops
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      wp_q <= '0;
      rp_q <= '0;
      cnt_q <= '0;
      in_ready_q <= 1'b1;
      out_valid_q <= 1'b0;
    end else begin
      wp_q <= wp_d;
      rp_q <= rp_d;
      cnt_q <= cnt_d;
      in_ready_q <= in_ready_d;
      out_valid_q <= out_valid_d;
    end
  end

  // Storage has no reset, only written on accepted words
  always_ff @(posedge clk_sys) begin
    if (push) begin
      mem[wp_q] <= in_data;
    end
  end
endmodule

// *** src/acm_isqrt.sv ***
// Sequential integer square root, two radicand bits per cycle
`timescale 1ns/1ps
module acm_isqrt (
  // Clock and reset
  input logic clk_sys,
  input logic arst_n,
  // Request
  input logic start,
  input logic [23:0] radicand,
  // Answer
  output logic [11:0] root,
  output logic done
);
  logic [23:0] op_q, op_d, res_q, res_d, one_q, one_d;
  logic done_q, done_d;

  assign root = res_q[11:0];
  assign done = done_q;

  // Digit-by-digit method, finishes when the trial bit shifts out
  always_comb begin
    op_d = op_q;
    res_d = res_q;
    one_d = one_q;
    done_d = 1'b0;
    if (start) begin
      op_d = radicand;
      res_d = '0;
      one_d = 24'h400000;
    end else if (one_q != '0) begin
      if (op_q >= res_q + one_q) begin
        op_d = op_q - (res_q + one_q);
        res_d = (res_q >> 1) + one_q;
      end else begin
        res_d = res_q >> 1;
      end
      one_d = one_q >> 2;
      done_d = (one_q[1:0] != 2'h0);
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      op_q <= '0;
      res_q <= '0;
      one_q <= '0;
      done_q <= 1'b0;
    end else begin
      op_q <= op_d;
      res_q <= res_d;
      one_q <= one_d;
      done_q <= done_d;
    end
  end
endmodule

// *** src/acm_meter_top.sv ***
// AC RMS current meter: sampling, noise calibration, RMS and current math
// How it works
// - Derive 3 and 6 MHz clock rates; each clk_sys edge stands in for a 24 MHz step
// - Request samples at about 5940 per second
// - Average two seconds of noise after reset
// - Subtract noise offset from every measured sample
// - Take one sample per converter ready event
// - Square corrected sample, add to running sum
// - At 5940 samples hold sum, clear, continue
// - Divide held sum, square root, overlapped
// - Publish peak-to-peak once per second
// - Scale codes by 3.3 V over 4095
// - Below 15 mV RMS report zero current
// - Second-order polynomial converts millivolts to current
// - One gain factor applied before polynomial
`timescale 1ns/1ps
module acm_meter_top import acm_pkg::*; #(
  parameter int SAMPLES_PER_IVL = SAMPLE_HZ,
  parameter int CAL_SAMPLES_P = CAL_SAMPLES
) (
  // Clock and reset
  input logic clk_sys,
  input logic arst_n,
  // Converter side
  output logic adc_start,
  input logic adc_sample_ready,
  input logic [ADC_W-1:0] adc_code,
  output logic adc_ready,
  // Calibration input, Q2.14 gain factor
  input logic [15:0] gain_corr,
  // Slow rate enables for neighbouring logic
  output logic aux_tick,
  output logic sub_main_tick,
  // Results
  output acm_result_s result,
  output logic result_valid,
  output logic calibrating
);
  localparam logic [CNT_W-1:0] IVL_LAST = CNT_W'(SAMPLES_PER_IVL - 1);
  localparam logic [CNT_W-1:0] CAL_LAST = CNT_W'(CAL_SAMPLES_P - 1);
  localparam logic [SMP_W-1:0] SMP_LAST = SMP_W'(SMP_DIV - 1);

  typedef enum logic [1:0] {SP_CAL, SP_WAIT, SP_RUN, SP_SQ} acm_sp_e;
  typedef enum logic [2:0] {MT_IDLE, MT_DCAL, MT_DMS, MT_SQRT, MT_DV, MT_POLY} acm_mt_e;

  // ****************************************
  // Rate enables
  // ****************************************
  logic [PH_W-1:0] aux_ph_q, aux_ph_d, sub_ph_q, sub_ph_d;
  logic aux_c, sub_c;
  logic [SMP_W-1:0] smp_div_q, smp_div_d;
  logic aux_tick_q, sub_tick_q, adc_start_q, adc_start_d;

  // Every clk_sys edge acts as a main clock step; 24 MHz cannot be reached from 20 MHz
  always_comb begin
    {aux_c, aux_ph_d} = {1'b0, aux_ph_q} + {1'b0, AUX_INC};
    {sub_c, sub_ph_d} = {1'b0, sub_ph_q} + {1'b0, SUB_INC};
    smp_div_d = smp_div_q;
    adc_start_d = 1'b0;
    if (sub_c) begin
      if (smp_div_q == SMP_LAST) begin
        smp_div_d = '0;
        adc_start_d = 1'b1;
      end else begin
        smp_div_d = smp_div_q + 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      aux_ph_q <= '0;
      sub_ph_q <= '0;
      smp_div_q <= '0;
      aux_tick_q <= 1'b0;
      sub_tick_q <= 1'b0;
      adc_start_q <= 1'b0;
    end else begin
      aux_ph_q <= aux_ph_d;
      sub_ph_q <= sub_ph_d;
      smp_div_q <= smp_div_d;
      aux_tick_q <= aux_c;
      sub_tick_q <= sub_c;
      adc_start_q <= adc_start_d;
    end
  end

  assign aux_tick = aux_tick_q;
  assign sub_main_tick = sub_tick_q;
  assign adc_start = adc_start_q;

  // ****************************************
  // Sample buffer
  // ****************************************
  acm_sample_s f_word;
  logic f_valid, pop;

  // Words offered while the buffer is full are not taken; adc_ready warns the converter
  acm_fifo #(.WIDTH($bits(acm_sample_s)), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk_sys(clk_sys),
    .arst_n(arst_n),
    .in_valid(adc_sample_ready),
    .in_data(adc_code),
    .in_ready(adc_ready),
    .out_valid(f_valid),
    .out_data(f_word),
    .out_ready(pop)
  );

  // ****************************************
  // Sample path
  // ****************************************
  acm_sp_e sp_q, sp_d;
  logic [CNT_W-1:0] cnt_q, cnt_d;
  logic [ACC_W-1:0] cal_sum_q, cal_sum_d, acc_q, acc_d, hold_q, hold_d;
  logic [ADC_W-1:0] code_q, code_d, mx_q, mx_d, mn_q, mn_d, hmx_q, hmx_d, hmn_q, hmn_d;
  logic cal_go_q, cal_go_d, ivl_go_q, ivl_go_d, cal_q;
  logic [ADC_W-1:0] off_q, off_d;
  logic off_ld_q, off_ld_d;
  logic signed [12:0] corr;
  logic signed [25:0] sq_s;
  logic [ACC_W-1:0] sq_ext;

  assign corr = $signed({1'b0, code_q}) - $signed({1'b0, off_q});
  assign sq_s = corr * corr;
  assign sq_ext = {{(ACC_W - 26){1'b0}}, sq_s};

  // Draining stalls while the offset is computed, so the buffer takes the slack
  always_comb begin
    sp_d = sp_q;
    cnt_d = cnt_q;
    cal_sum_d = cal_sum_q;
    acc_d = acc_q;
    hold_d = hold_q;
    code_d = code_q;
    mx_d = mx_q;
    mn_d = mn_q;
    hmx_d = hmx_q;
    hmn_d = hmn_q;
    cal_go_d = 1'b0;
    ivl_go_d = 1'b0;
    pop = 1'b0;
    case (sp_q)
      SP_CAL: if (f_valid) begin
        pop = 1'b1;
        cal_sum_d = cal_sum_q + ACC_W'(f_word.code);
        if (cnt_q == CAL_LAST) begin
          cnt_d = '0;
          cal_go_d = 1'b1;
          sp_d = SP_WAIT;
        end else begin
          cnt_d = cnt_q + 1'b1;
        end
      end
      SP_WAIT: if (off_ld_q) begin
        sp_d = SP_RUN;
      end
      SP_RUN: if (f_valid) begin
        pop = 1'b1;
        code_d = f_word.code;
        if (f_word.code > mx_q) mx_d = f_word.code;
        if (f_word.code < mn_q) mn_d = f_word.code;
        sp_d = SP_SQ;
      end
      SP_SQ: begin
        sp_d = SP_RUN;
        if (cnt_q == IVL_LAST) begin
          hold_d = acc_q + sq_ext;
          acc_d = '0;
          cnt_d = '0;
          hmx_d = mx_q;
          hmn_d = mn_q;
          mx_d = MX_RST;
          mn_d = MN_RST;
          ivl_go_d = 1'b1;
        end else begin
          acc_d = acc_q + sq_ext;
          cnt_d = cnt_q + 1'b1;
        end
      end
      default: sp_d = SP_CAL;
    endcase
  end

  // Reset restarts from the noise calibration with all sums cleared
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      sp_q <= SP_CAL;
      cnt_q <= '0;
      cal_sum_q <= '0;
      acc_q <= '0;
      hold_q <= '0;
      code_q <= '0;
      mx_q <= MX_RST;
      mn_q <= MN_RST;
      hmx_q <= '0;
      hmn_q <= '0;
      cal_go_q <= 1'b0;
      ivl_go_q <= 1'b0;
      cal_q <= 1'b1;
    end else begin
      sp_q <= sp_d;
      cnt_q <= cnt_d;
      cal_sum_q <= cal_sum_d;
      acc_q <= acc_d;
      hold_q <= hold_d;
      code_q <= code_d;
      mx_q <= mx_d;
      mn_q <= mn_d;
      hmx_q <= hmx_d;
      hmn_q <= hmn_d;
      cal_go_q <= cal_go_d;
      ivl_go_q <= ivl_go_d;
      cal_q <= (sp_d == SP_CAL) || (sp_d == SP_WAIT);
    end
  end

  assign calibrating = cal_q;

  // ****************************************
  // Math path
  // ****************************************
  acm_mt_e mt_q, mt_d;
  logic [ACC_W-1:0] dq_q, dq_d, dd_q, dd_d;
  logic [ACC_W:0] dr_q, dr_d, rem_t;
  logic [5:0] dn_q, dn_d;
  logic [ADC_W-1:0] rms_q, rms_d, sq_root;
  logic [19:0] xv_q, xv_d;
  logic sqrt_go, sq_done;
  logic [35:0] xg_full;
  logic signed [63:0] xg_s, y_s;
  logic [15:0] cur_ma;
  acm_result_s res_q, res_d;
  logic res_valid_q, res_valid_d;

  acm_isqrt u_isqrt (
    .clk_sys(clk_sys),
    .arst_n(arst_n),
    .start(sqrt_go),
    .radicand(dq_q[23:0]),
    .root(sq_root),
    .done(sq_done)
  );

  // Gain-corrected voltage, then the polynomial in mA scaled by 2^16
  assign xg_full = xv_q * gain_corr;
  assign xg_s = $signed({{(64 - 36 + GAIN_FRAC){1'b0}}, xg_full[35:GAIN_FRAC]});
  assign y_s = ((COEF_A_Q * (xg_s * xg_s)) >>> POLY_Q) + ((COEF_B_Q * xg_s) >>> XQ) + COEF_C_Q;
  always_comb begin
    if (xv_q < THR_XQ || y_s < 0) begin
      cur_ma = '0;
    end else if (y_s[63:32] != '0) begin
      cur_ma = 16'hFFFF;
    end else begin
      cur_ma = y_s[31:16];
    end
  end

  // One shared restoring divider; the whole chain runs inside the next interval
  always_comb begin
    mt_d = mt_q;
    dq_d = dq_q;
    dr_d = dr_q;
    dd_d = dd_q;
    dn_d = dn_q;
    off_d = off_q;
    off_ld_d = 1'b0;
    rms_d = rms_q;
    xv_d = xv_q;
    res_d = res_q;
    res_valid_d = 1'b0;
    sqrt_go = 1'b0;
    rem_t = {dr_q[ACC_W-1:0], dq_q[ACC_W-1]};
    if (dn_q != '0) begin
      if (rem_t >= {1'b0, dd_q}) begin
        dr_d = rem_t - {1'b0, dd_q};
        dq_d = {dq_q[ACC_W-2:0], 1'b1};
      end else begin
        dr_d = rem_t;
        dq_d = {dq_q[ACC_W-2:0], 1'b0};
      end
      dn_d = dn_q - 1'b1;
    end
    case (mt_q)
      MT_IDLE: if (cal_go_q) begin
        dq_d = cal_sum_q;
        dd_d = ACC_W'(CAL_SAMPLES_P);
        dr_d = '0;
        dn_d = 6'(ACC_W);
        mt_d = MT_DCAL;
      end else if (ivl_go_q) begin
        dq_d = hold_q;
        dd_d = ACC_W'(SAMPLES_PER_IVL);
        dr_d = '0;
        dn_d = 6'(ACC_W);
        mt_d = MT_DMS;
      end
      MT_DCAL: if (dn_q == '0) begin
        off_d = dq_q[ADC_W-1:0];
        off_ld_d = 1'b1;
        mt_d = MT_IDLE;
      end
      MT_DMS: if (dn_q == '0) begin
        sqrt_go = 1'b1;
        mt_d = MT_SQRT;
      end
      MT_SQRT: if (sq_done) begin
        rms_d = sq_root;
        dq_d = ACC_W'(sq_root) * ACC_W'(VREF_MV << XQ);
        dd_d = ACC_W'(ADC_FULL);
        dr_d = '0;
        dn_d = 6'(ACC_W);
        mt_d = MT_DV;
      end
      MT_DV: if (dn_q == '0) begin
        xv_d = dq_q[19:0];
        mt_d = MT_POLY;
      end
      MT_POLY: begin
        res_d = '{rms: rms_q, pp: hmx_q - hmn_q, cur_ma: cur_ma};
        res_valid_d = 1'b1;
        mt_d = MT_IDLE;
      end
      default: mt_d = MT_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      mt_q <= MT_IDLE;
      dq_q <= '0;
      dr_q <= '0;
      dd_q <= '0;
      dn_q <= '0;
      off_q <= '0;
      off_ld_q <= 1'b0;
      rms_q <= '0;
      xv_q <= '0;
      res_q <= '0;
      res_valid_q <= 1'b0;
    end else begin
      mt_q <= mt_d;
      dq_q <= dq_d;
      dr_q <= dr_d;
      dd_q <= dd_d;
      dn_q <= dn_d;
      off_q <= off_d;
      off_ld_q <= off_ld_d;
      rms_q <= rms_d;
      xv_q <= xv_d;
      res_q <= res_d;
      res_valid_q <= res_valid_d;
    end
  end

  assign result = res_q;
  assign result_valid = res_valid_q;

  // ****************************************
  // Checks
  // ****************************************
  chk_aux_rate: assert property (@(posedge clk_sys) disable iff (!arst_n)
    aux_tick_q |=> !aux_tick_q) else $error("aux tick too fast");
  chk_start_gap: assert property (@(posedge clk_sys) disable iff (!arst_n)
    adc_start_q |=> !adc_start_q [*8]) else $error("sample starts too close");
  chk_cal_quiet: assert property (@(posedge clk_sys) disable iff (!arst_n)
    cal_q |-> !res_valid_q && !ivl_go_q) else $error("result during calibration");
  chk_off_wait: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (sp_q == SP_WAIT && !off_ld_q) |=> sp_q == SP_WAIT) else $error("left wait without offset");
  chk_pop_valid: assert property (@(posedge clk_sys) disable iff (!arst_n)
    pop |-> f_valid && (sp_q == SP_CAL || sp_q == SP_RUN)) else $error("pop without sample");
  chk_acc_step: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (sp_q == SP_SQ && cnt_q != IVL_LAST) |=> acc_q == $past(acc_q) + $past(sq_ext))
    else $error("square not accumulated");
  chk_ivl_wrap: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (sp_q == SP_SQ && cnt_q == IVL_LAST) |=> acc_q == '0 && cnt_q == '0 && ivl_go_q && sp_q == SP_RUN)
    else $error("interval wrap wrong");
  chk_math_lat: assert property (@(posedge clk_sys) disable iff (!arst_n)
    ivl_go_q |-> ##[95:100] res_valid_q) else $error("result late");
  chk_zero_thr: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (mt_q == MT_POLY && xv_q < THR_XQ) |=> res_valid_q && res_q.cur_ma == '0) else $error("noise not zeroed");
  chk_res_hold: assert property (@(posedge clk_sys) disable iff (!arst_n)
    !res_valid_q |-> $stable(res_q)) else $error("result moved without strobe");
endmodule

// *** dv/acm_adc_model.sv ***
// Behavioural converter model that offers coded words toward the meter
`timescale 1ns/1ps
module acm_adc_model import acm_pkg::*; (
  // Clock
  input wire logic clk_sys,
  // Flow control from the meter
  input wire logic adc_ready,
  // Word offer
  output logic adc_sample_ready,
  output logic [ADC_W-1:0] adc_code
);
  // ****************************************
  // Word queue and offer logic
  // ****************************************
  // Entry: idle cycles before the word above bit 16, code below
  int words[$];
  int wait_q = 0;
  logic took_q = 1'b0;

  initial begin
    adc_sample_ready = 1'b0;
    adc_code = 12'hA5A;
  end

  // Note whether the word on offer was taken at this edge
  always @(posedge clk_sys) begin
    took_q <= adc_sample_ready & adc_ready;
  end

  // Offer off the falling edge and hold until taken; idle data toggles so it never matches by luck
  always @(negedge clk_sys) begin
    if (!adc_sample_ready || took_q) begin
      if (words.size() > 0 && wait_q >= (words[0] >> 16)) begin
        adc_sample_ready <= 1'b1;
        adc_code <= words[0][ADC_W-1:0];
        void'(words.pop_front());
        wait_q <= 0;
      end else begin
        adc_sample_ready <= 1'b0;
        adc_code <= ~adc_code;
        wait_q <= wait_q + 1;
      end
    end
  end
endmodule

// *** dv/acm_meter_top_tb_top.sv ***
// Self-checking bench for the AC RMS current meter
`timescale 1ns/1ps
`define CHK(act, exp) begin samples_checked++; if ((act) !== (exp)) begin fails++; \
  $display("MISMATCH t=%0t act=%0h exp=%0h", $time, (act), (exp)); end end
module acm_meter_top_tb_top import acm_pkg::*; ;
  // ****************************************
  // Signals, design and converter model
  // ****************************************
  localparam int IVL = 16;
  localparam int CAL = 8;
  localparam int AMP_T [5] = '{200, 200, 18, 19, 0};
  localparam logic [15:0] GAIN_T [5] = '{16'h4000, 16'h2000, 16'h8000, 16'h4000, 16'h4000};
  logic clk_sys, arst_n, adc_start, adc_sample_ready, adc_ready, aux_tick, sub_main_tick;
  logic result_valid, calibrating;
  logic [ADC_W-1:0] adc_code;
  logic [15:0] gain_corr;
  acm_result_s result, prev_res;
  int fails = 0;
  int samples_checked = 0;
  logic res_moved = 1'b0;
  logic ready_low_seen = 1'b0;

  acm_meter_top #(.SAMPLES_PER_IVL(IVL), .CAL_SAMPLES_P(CAL)) dut_u (.clk_sys(clk_sys), .arst_n(arst_n),
    .adc_start(adc_start), .adc_sample_ready(adc_sample_ready), .adc_code(adc_code), .adc_ready(adc_ready),
    .gain_corr(gain_corr), .aux_tick(aux_tick), .sub_main_tick(sub_main_tick), .result(result),
    .result_valid(result_valid), .calibrating(calibrating));
  acm_adc_model adc_m (.clk_sys(clk_sys), .adc_ready(adc_ready), .adc_sample_ready(adc_sample_ready),
    .adc_code(adc_code));

  // 20 MHz clock
  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end

  // Watch for results moving between strobes and for the buffer refusing words
  always @(negedge clk_sys) begin
    if (arst_n === 1'b1 && result_valid !== 1'b1 && result !== prev_res) res_moved = 1'b1;
    if (adc_ready === 1'b0) ready_low_seen = 1'b1;
    prev_res = result;
  end

  // ****************************************
  // Helpers
  // ****************************************
  task automatic stop_test;
    $display("Comparisons %0d, mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // Watched outputs for the bounded wait
  localparam int W_RES = 0;
  localparam int W_CAL = 1;
  localparam int W_START = 2;

  // Bounded wait for a level on one watched output; running out ends the run
  task automatic wait_level(input int sel, input logic lvl, input int lim);
    int i;
    logic v;
    for (i = 0; i < lim; i++) begin
      @(negedge clk_sys);
      v = (sel == W_RES) ? result_valid : ((sel == W_CAL) ? calibrating : adc_start);
      if (v === lvl) break;
    end
    if (i == lim) begin
      fails++;
      $display("Wait limit exceeded at %0t", $time);
      stop_test;
    end
  endtask

  function automatic void push(int code, int gap);
    adc_m.words.push_back((gap << 16) | code);
  endfunction

  // Alternate mid+a and mid-a so the corrected RMS is a and the swing is 2a
  function automatic void push_ivl(int mid, int a, int gap);
    for (int i = 0; i < IVL; i++) push(mid + ((i % 2 == 0) ? a : -a), gap);
  endfunction

  task automatic wait_empty;
    int i;
    for (i = 0; i < 800; i++) begin
      @(negedge clk_sys);
      if (adc_m.words.size() == 0 && adc_sample_ready === 1'b0) break;
    end
    if (i == 800) begin
      fails++;
      stop_test;
    end
  endtask

  // Expected current in mA; real math, so the design gets a small tolerance for its rounding
  function automatic int exp_ma(int a, int g);
    int xq;
    real x;
    xq = a * 3300 * 256 / 4095;
    if (xq < THR_MV * 256) return 0;
    x = real'(xq) * g / 16384.0 / 256.0;
    return $rtoi((COEF_A * x * x + COEF_B * x + COEF_C) * 1000.0);
  endfunction

  task automatic chk_result(int a, logic [15:0] g);
    int e, d;
    wait_level(W_RES, 1'b1, 3000);
    `CHK(result.rms, 12'(a))
    `CHK(result.pp, 12'(2 * a))
    e = exp_ma(a, g);
    d = int'(result.cur_ma) - e;
    if (e == 0) begin
      `CHK(result.cur_ma, 16'h0)
    end else begin
      `CHK((d >= -6 && d <= 6 && !$isunknown(result.cur_ma)), 1'b1)
    end
    @(negedge clk_sys);
    `CHK(result_valid, 1'b0)
  endtask

  task automatic chk_reset_state;
    `CHK(result, 36'h0)
    `CHK(result_valid, 1'b0)
    `CHK(calibrating, 1'b1)
    `CHK(adc_ready, 1'b1)
    `CHK(adc_start, 1'b0)
    `CHK({aux_tick, sub_main_tick}, 2'b00)
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  // Seven of eight noise words must leave calibration running
  task automatic chk_calib;
    for (int i = 0; i < CAL - 1; i++) push(2044 + i, 3);
    wait_empty;
    repeat (20) @(negedge clk_sys);
    `CHK(calibrating, 1'b1)
  endtask

  // Last noise word, then a burst during the offset divide so the buffer fills, then paced intervals
  task automatic chk_measure;
    push(2051, 0);
    for (int k = 0; k < 5; k++) push_ivl(2047, AMP_T[k], (k == 0) ? 0 : 12);
    wait_level(W_CAL, 1'b0, 300);
    `CHK(calibrating, 1'b0)
    for (int k = 0; k < 5; k++) begin
      chk_result(AMP_T[k], GAIN_T[k]);
      if (k < 4) gain_corr = GAIN_T[k + 1];
    end
    `CHK(ready_low_seen, 1'b1)
    `CHK(res_moved, 1'b0)
  endtask

  // Start spacing of 1010 sub-main ticks and the two slow tick rates
  task automatic chk_rates;
    int n, aux_n, sub_n;
    wait_level(W_START, 1'b1, 4000);
    n = 0;
    aux_n = 0;
    sub_n = 0;
    do begin
      @(negedge clk_sys);
      n++;
      aux_n += int'(aux_tick);
      sub_n += int'(sub_main_tick);
    end while (adc_start !== 1'b1 && n < 4000);
    `CHK((n >= 3366 && n <= 3368), 1'b1)
    `CHK((sub_n >= 1009 && sub_n <= 1011), 1'b1)
    `CHK((aux_n >= n * 3 / 20 - 1 && aux_n <= n * 3 / 20 + 1), 1'b1)
  endtask

  // Reset in mid-interval must discard the partial sums and restart calibration
  task automatic chk_restart;
    for (int i = 0; i < 5; i++) push(3000, 2);
    wait_empty;
    arst_n = 1'b0;
    @(negedge clk_sys);
    chk_reset_state;
    repeat (2) @(negedge clk_sys);
    arst_n = 1'b1;
    @(negedge clk_sys);
    `CHK(calibrating, 1'b1)
    for (int i = 0; i < CAL; i++) push(1000, 1);
    push_ivl(1000, 100, 12);
    chk_result(100, gain_corr);
  endtask

  // Main sequence
  initial begin
    arst_n = 1'b0;
    gain_corr = GAIN_ONE;
    repeat (12) @(negedge clk_sys);
    chk_reset_state;
    arst_n = 1'b1;
    chk_calib;
    chk_measure;
    chk_rates;
    chk_restart;
    stop_test;
  end
endmodule
